// >>> pmts_top.sv
// master transaction status vector generator
`timescale 1ns/100ps
`include "pmts_consts.svh"
module pmts_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txn_want,
  input wire logic gnt_active,
  input wire logic adr_phase_start,
  input wire logic data_xfer,
  input wire logic txn_done,
  input wire logic lat_expired,
  input wire logic tgt_retry,
  input wire logic tgt_disc_nodata,
  input wire logic tgt_disc_withdata,
  input wire logic tgt_ack64,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic req_drive,
  output pmts_pkg::pmts_vec_t master_txn_status_bus,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    pmts_pkg::pmts_state_e fsm;
    pmts_pkg::pmts_vec_t stat;
    logic req;
  } pmts_top_s;
  pmts_top_s st_r, st_nxt;
  logic [4:0] flags;
  logic [4:0] clr;
  logic [4:0] ien;
  logic wide_en;
  logic irq_w;
  logic [4:0] ev;
  // ------------------------------------------------------------
  // transaction sequencing
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.stat[`PMTS_B_XFR] = 1'b0;
    st_nxt.stat[`PMTS_B_ADR] = 1'b0;
    unique case (st_r.fsm)
      pmts_pkg::PMTS_IDLE: begin
        if (txn_want) begin
          // parked grant skips the request step
          if (gnt_active) begin
            st_nxt.fsm = pmts_pkg::PMTS_ADR;
            st_nxt.stat[`PMTS_B_GNT] = 1'b1;
            st_nxt.stat[`PMTS_B_ADR] = 1'b1;
          end else begin
            st_nxt.fsm = pmts_pkg::PMTS_REQ;
            st_nxt.req = 1'b1;
            st_nxt.stat[`PMTS_B_REQ] = 1'b1;
          end
          st_nxt.stat[`PMTS_B_LAT] = 1'b0;
          st_nxt.stat[`PMTS_B_RTY] = 1'b0;
          st_nxt.stat[`PMTS_B_DWOD] = 1'b0;
          st_nxt.stat[`PMTS_B_DWD] = 1'b0;
          st_nxt.stat[`PMTS_B_W64] = 1'b0;
        end
      end
      pmts_pkg::PMTS_REQ: begin
        st_nxt.stat[`PMTS_B_GNT] = gnt_active;
        // grant may be withdrawn before our address phase
        if (gnt_active && adr_phase_start) begin
          st_nxt.fsm = pmts_pkg::PMTS_ADR;
          st_nxt.req = 1'b0;
          st_nxt.stat[`PMTS_B_REQ] = 1'b0;
          st_nxt.stat[`PMTS_B_ADR] = 1'b1;
        end
      end
      pmts_pkg::PMTS_ADR: begin
        st_nxt.fsm = pmts_pkg::PMTS_DAT;
        st_nxt.stat[`PMTS_B_GNT] = 1'b0;
        st_nxt.stat[`PMTS_B_DAT] = 1'b1;
      end
      pmts_pkg::PMTS_DAT: begin
        st_nxt.stat[`PMTS_B_XFR] = data_xfer;
        if (tgt_ack64 && wide_en) begin
          st_nxt.stat[`PMTS_B_W64] = 1'b1;
        end
        if (txn_done) begin
          st_nxt.fsm = pmts_pkg::PMTS_TA;
          st_nxt.stat[`PMTS_B_DAT] = 1'b0;
          // one termination cause, priority target over timer
          if (tgt_retry) begin
            st_nxt.stat[`PMTS_B_RTY] = 1'b1;
          end else if (tgt_disc_withdata) begin
            st_nxt.stat[`PMTS_B_DWD] = 1'b1;
          end else if (tgt_disc_nodata) begin
            st_nxt.stat[`PMTS_B_DWOD] = 1'b1;
          end else if (lat_expired) begin
            st_nxt.stat[`PMTS_B_LAT] = 1'b1;
          end
        end
      end
      pmts_pkg::PMTS_TA: begin
        st_nxt.fsm = pmts_pkg::PMTS_IDLE;
      end
      default: begin
        st_nxt.fsm = pmts_pkg::PMTS_IDLE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{fsm: pmts_pkg::PMTS_IDLE, stat: `PMTS_RST_10, req: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  // ------------------------------------------------------------
  // events and registers
  // ------------------------------------------------------------
  // flags capture the four cause bits as they are raised, and flag 0 each address phase
  assign ev = {st_nxt.stat[`PMTS_B_DWD] & ~st_r.stat[`PMTS_B_DWD],
               st_nxt.stat[`PMTS_B_DWOD] & ~st_r.stat[`PMTS_B_DWOD],
               st_nxt.stat[`PMTS_B_RTY] & ~st_r.stat[`PMTS_B_RTY],
               st_nxt.stat[`PMTS_B_LAT] & ~st_r.stat[`PMTS_B_LAT],
               st_nxt.stat[`PMTS_B_ADR]};
  pmts_sticky u_sticky (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(ev),
    .clr_i(clr),
    .en_i(ien),
    .flag_o(flags),
    .irq_o(irq_w)
  );
  pmts_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .stat_i(st_r.stat),
    .flag_i(flags),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .clr_o(clr),
    .ien_o(ien),
    .wide_en_o(wide_en)
  );
  assign master_txn_status_bus = st_r.stat;
  assign req_drive = st_r.req;
  assign irq = irq_w;
endmodule : pmts_top

// >>> pmts_consts.svh
// constants for the master transaction status block
`ifndef PMTS_CONSTS_SVH
`define PMTS_CONSTS_SVH
`define PMTS_W 10
`define PMTS_B_REQ 0
`define PMTS_B_GNT 1
`define PMTS_B_ADR 2
`define PMTS_B_DAT 3
`define PMTS_B_LAT 4
`define PMTS_B_RTY 5
`define PMTS_B_DWOD 6
`define PMTS_B_DWD 7
`define PMTS_B_XFR 8
`define PMTS_B_W64 9
`define PMTS_RST_10 10'h000
`define PMTS_APB_STAT 12'h000
`define PMTS_APB_FLAG 12'h004
`define PMTS_APB_CLR 12'h008
`define PMTS_APB_IEN 12'h00c
`define PMTS_APB_CTRL 12'h010
`define PMTS_FLAG_W 5
`define PMTS_CTRL_W 1
`define PMTS_ZERO32 32'h0000_0000
`endif

// >>> pmts_pkg.sv
// types for the master transaction status block
package pmts_pkg;
  typedef enum logic [4:0] {
    PMTS_IDLE = 5'h01,
    PMTS_REQ = 5'h02,
    PMTS_ADR = 5'h04,
    PMTS_DAT = 5'h08,
    PMTS_TA = 5'h10
  } pmts_state_e;
  typedef logic [9:0] pmts_vec_t;
endpackage : pmts_pkg

// >>> pmts_sticky.sv
// sticky event flags with write-one clear and enable mask
`timescale 1ns/100ps
`include "pmts_consts.svh"
module pmts_sticky (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] set_i,
  input wire logic [4:0] clr_i,
  input wire logic [4:0] en_i,
  output logic [4:0] flag_o,
  output logic irq_o
);
  typedef struct packed {
    logic [4:0] flag;
    logic irq;
  } pmts_stk_s;
  pmts_stk_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    // set beats clear in the same cycle
    st_nxt.flag = (st_r.flag & ~clr_i) | set_i;
    st_nxt.irq = |(st_nxt.flag & en_i);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign flag_o = st_r.flag;
  assign irq_o = st_r.irq;
endmodule : pmts_sticky

// >>> pmts_apb.sv
// apb slave for status, flags, enable and control
`timescale 1ns/100ps
`include "pmts_consts.svh"
module pmts_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [9:0] stat_i,
  input wire logic [4:0] flag_i,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [4:0] clr_o,
  output logic [4:0] ien_o,
  output logic wide_en_o
);
  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [4:0] clr;
    logic [4:0] ien;
    logic wide_en;
  } pmts_apb_s;
  pmts_apb_s st_r, st_nxt;
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PMTS_APB_STAT) || (a == `PMTS_APB_FLAG) || (a == `PMTS_APB_CLR)
      || (a == `PMTS_APB_IEN) || (a == `PMTS_APB_CTRL);
  endfunction : mapped
  always_comb begin
    st_nxt = st_r;
    st_nxt.clr = '0;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    // answer one cycle into the access phase
    if (psel && penable && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.err = !mapped(paddr);
      st_nxt.rdata = `PMTS_ZERO32;
      if (!pwrite) begin
        unique case (paddr)
          `PMTS_APB_STAT: st_nxt.rdata = {22'h00_0000, stat_i};
          `PMTS_APB_FLAG: st_nxt.rdata = {27'h000_0000, flag_i};
          `PMTS_APB_IEN: st_nxt.rdata = {27'h000_0000, st_r.ien};
          `PMTS_APB_CTRL: st_nxt.rdata = {31'h0000_0000, st_r.wide_en};
          default: st_nxt.rdata = `PMTS_ZERO32;
        endcase
      end
    end
    // writes land only on the edge that samples pready high
    if (psel && penable && st_r.ready && pwrite) begin
      if (paddr == `PMTS_APB_CLR) begin
        st_nxt.clr = pwdata[4:0];
      end
      if (paddr == `PMTS_APB_IEN) begin
        st_nxt.ien = pwdata[4:0];
      end
      if (paddr == `PMTS_APB_CTRL) begin
        st_nxt.wide_en = pwdata[0];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign clr_o = st_r.clr;
  assign ien_o = st_r.ien;
  assign wide_en_o = st_r.wide_en;
endmodule : pmts_apb

// >>> pmts_monitor.sv
// checker of the status vector timing
`timescale 1ns/100ps
module pmts_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic txn_want,
  input wire logic gnt_active,
  input wire logic adr_phase_start,
  input wire logic data_xfer,
  input wire logic txn_done,
  input wire logic tgt_retry,
  input wire logic req_drive,
  input wire pmts_pkg::pmts_vec_t master_txn_status_bus,
  input wire logic irq
);
  wire [9:0] s = master_txn_status_bus;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------
  // assertions
  // ----------
  chk_req_line: assert property (s[0] == req_drive && !(s[0] && (s[2] || s[3]))) else $error("req bit");
  chk_parked_noreq: assert property (s[3:0] == 4'h0 && txn_want && gnt_active |=> !s[0]) else $error("park");
  chk_grant_seen: assert property (s[0] && gnt_active |=> s[1]) else $error("grant");
  chk_adr_enter: assert property (s[0] && gnt_active && adr_phase_start |=> s[2] && !s[0]) else $error("adr");
  chk_adr_once: assert property (s[2] |=> !s[2] && s[3] && !s[1]) else $error("adr len");
  chk_dat_end: assert property (s[3] && txn_done |=> !s[3] ##1 !s[3]) else $error("dat end");
  chk_xfer_pulse: assert property (s[3] && data_xfer |=> s[8]) else $error("xfer");
  chk_retry_cause: assert property (s[3] && txn_done && tgt_retry |=> s[5]) else $error("retry");
  chk_reset_zero: assert property ($rose(presetn) |-> s == 10'h000 && !irq) else $error("reset");
endmodule : pmts_monitor

bind pmts_top pmts_monitor u_mon (.pclk, .presetn, .txn_want, .gnt_active, .adr_phase_start,
  .data_xfer, .txn_done, .tgt_retry, .req_drive, .master_txn_status_bus, .irq);

// >>> pmts_local.sv
// local side model that starts and reissues transactions
`timescale 1ns/100ps
module pmts_local (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire pmts_pkg::pmts_vec_t status,
  output logic txn_want
);
  logic retry_q;
  // explicit history bit keeps the edge detect on the clock alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retry_q <= 1'h0;
    end else begin
      retry_q <= status[5];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txn_want <= 1'h0;
    end else if (go || (status[5] && !retry_q)) begin
      txn_want <= 1'h1;
    end else if (status[2]) begin // grant may be withdrawn, so hold until address phase
      txn_want <= 1'h0;
    end
  end
endmodule : pmts_local

// >>> testbench.sv
// self-checking bench for the master transaction status block
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, go, txn_want, gnt_active, adr_phase_start, data_xfer, txn_done;
  logic lat_expired, tgt_retry, tgt_disc_nodata, tgt_disc_withdata, tgt_ack64;
  logic psel, penable, pwrite, pready, pslverr, req_drive, irq, er, wide;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  pmts_pkg::pmts_vec_t s;
  int n_fail = 0;
  int n_compared = 0;
  int n_cyc = 0;
  pmts_top dut (.pclk, .presetn, .txn_want, .gnt_active, .adr_phase_start, .data_xfer, .txn_done,
    .lat_expired, .tgt_retry, .tgt_disc_nodata, .tgt_disc_withdata, .tgt_ack64, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_drive, .master_txn_status_bus(s), .irq);
  pmts_local u_local (.pclk, .presetn, .go, .status(s), .txn_want);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wait_bit(input int k);
    #1;
    while (s[k] !== 1'h1) begin
      @(posedge pclk);
      #1;
    end
  endtask : wait_bit
  // one transaction; a parked grant skips the request phase
  task automatic txn(input logic [3:0] cm, input logic [3:0] ex, input logic park, input logic ack);
    @(posedge pclk) gnt_active <= park;
    go <= 1'h1;
    @(posedge pclk) go <= 1'h0;
    if (!park) begin
      wait_bit(0);
      chk(req_drive, 1'h1);
      @(posedge pclk) gnt_active <= 1'h1;
      @(posedge pclk) gnt_active <= 1'h0;
      #1 chk(s[1:0], 2'h3);
      @(posedge pclk) gnt_active <= 1'h1;
      adr_phase_start <= 1'h1;
      #1 chk(s[1:0], 2'h1);
      @(posedge pclk) adr_phase_start <= 1'h0;
    end
    wait_bit(2);
    chk(s[2:0], 3'h6);
    @(posedge pclk) gnt_active <= 1'h0;
    data_xfer <= 1'h1;
    tgt_ack64 <= ack;
    #1 chk(s[3:1], 3'h4);
    @(posedge pclk) data_xfer <= 1'h0;
    tgt_ack64 <= 1'h0;
    txn_done <= 1'h1;
    {tgt_disc_withdata, tgt_disc_nodata, tgt_retry, lat_expired} <= cm;
    #1 chk(s[8], 1'h1);
    @(posedge pclk) txn_done <= 1'h0;
    {tgt_disc_withdata, tgt_disc_nodata, tgt_retry, lat_expired} <= 4'h0;
    #1 chk(s, {ack & wide, 1'h0, ex, 4'h0});
  endtask : txn
  // ----------
  // scenarios
  // ----------
  task automatic reset_check;
    #1 chk(s, 10'h000);
    chk(irq, 1'h0);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask : reset_check
  // several causes at once check the priority; retry leaves a reissue pending
  task automatic txn_walks;
    txn(4'h1, 4'h1, 1'h1, 1'h1);
    apb(1'h1, 12'h010, 32'h0000_0001);
    wide = 1'h1;
    txn(4'hf, 4'h2, 1'h0, 1'h1);
    txn(4'hd, 4'h8, 1'h0, 1'h0);
    txn(4'h5, 4'h4, 1'h0, 1'h0);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0040);
  endtask : txn_walks
  task automatic irq_flow;
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_001f);
    chk(irq, 1'h0);
    apb(1'h1, 12'h00c, 32'h0000_0002);
    @(posedge pclk) #1 chk(irq, 1'h1);
    apb(1'h1, 12'h008, 32'h0000_0002);
    @(posedge pclk) #1 chk(irq, 1'h0);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_001d);
    apb(1'h0, 12'h020, 32'h0000_0000);
    chk(er, 1'h1);
  endtask : irq_flow
  initial begin
    {pclk, presetn, go, gnt_active, adr_phase_start, data_xfer, txn_done, lat_expired, tgt_retry} = '0;
    {tgt_disc_nodata, tgt_disc_withdata, tgt_ack64, psel, penable, pwrite, paddr, pwdata, wide} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    reset_check();
    txn_walks();
    irq_flow();
    close_out();
  end
endmodule : testbench
